/* core/asrc_pkg.sv */
// shared constants for the asynchronous sram host controller
package asrc_pkg;
  localparam int ADDR_W = 14;            // word index width
  localparam int DATA_W = 4;             // data bus width
  localparam int CLK_PERIOD_NS = 10;     // system clock period
  // timing figures in ns, fastest grade
  localparam int T_CYCLE_NS = 12;        // least read or write cycle
  localparam int T_ACCESS_NS = 12;       // access time from select
  localparam int T_WPULSE_NS = 10;       // least write strobe width
  localparam int T_DSETUP_NS = 6;        // data valid before end of write
  localparam int T_HIZ_NS = 6;           // device release after deselect
  // cycle counts: least times round up, none below one
  localparam int RD_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WR_CYC = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_MIN = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (T_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  // phases of one bus cycle
  typedef enum logic [2:0] {ASRC_IDLE, ASRC_RD, ASRC_WR, ASRC_HOLD, ASRC_TURN} asrc_state_t;
endpackage

/* core/asrc_timer.sv */
// down counter that flags when a phase has lasted its cycles
`timescale 1ns/1ps
`default_nettype none
module asrc_timer #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  // status
  output logic done_o
);
  logic [W-1:0] cnt_reg;  // cycles left
  // reload on request, else count toward zero
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_reg <= '0;
    else if (load_i)
      cnt_reg <= value_i;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end
  assign done_o = (cnt_reg == '0);
endmodule
`default_nettype wire

/* core/asrc_host.sv */
// host controller driving a 16k x 4 asynchronous static memory
// What this block does
// - write only while select and strobe overlap low
// - strobe stays high through every read
// - each cycle lasts at least cycle time
// - address and strobe held 20 ns in write
// - data set up 20 ns before write end
// - select-controlled write lasts at least 8 ns
`timescale 1ns/1ps
`default_nettype none
module asrc_host #(
  parameter int ADDR_W = asrc_pkg::ADDR_W,
  parameter int DATA_W = asrc_pkg::DATA_W
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // user request port
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  // memory pins
  output logic [ADDR_W-1:0] word_index_o,
  output logic chip_sel_n_o,
  output logic wr_strobe_n_o,
  output logic out_en_n_o,
  input wire logic [DATA_W-1:0] data_io_i,
  output logic [DATA_W-1:0] data_io_o,
  output logic data_io_oe_o
);
  asrc_pkg::asrc_state_t state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg;       // held address
  logic [DATA_W-1:0] wdata_reg;      // held write data
  logic [DATA_W-1:0] rdata_reg;      // captured read data
  logic [DATA_W-1:0] sync1_reg;      // first synchroniser stage
  logic [DATA_W-1:0] sync2_reg;      // second synchroniser stage
  logic cs_n_reg, we_n_reg, oe_n_reg, doe_reg, ready_reg, rvalid_reg;
  logic load;                        // timer reload strobe
  logic [asrc_pkg::CNT_W-1:0] load_val;
  logic done;                        // phase time elapsed
  logic take;                        // request accepted
  logic take_rd, take_wr;
  logic nx_rd; // next phase is a read
  logic nx_wr; // next phase is a write strobe
  logic nx_hold; // next phase holds write data
  logic nx_idle; // next phase is idle
  logic cs_n_next; // select for the coming cycle
  logic we_n_next; // strobe for the coming cycle
  logic oe_n_next; // output enable for the coming cycle
  logic doe_next; // host bus drive for the coming cycle
  logic ready_next; // accepting in the coming cycle
  logic rd_done; // read phase over, capture the word

  // one down counter times every phase; a read keeps select low five
  // cycles so the synchronised word is older than the access time,
  // which trades some read speed for a capture that never races
  asrc_timer #(.W(asrc_pkg::CNT_W)) u_timer (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .load_i(load),
    .value_i(load_val),
    .done_o(done)
  );

  // decode of request acceptance; ready gates it so that nothing is
  // taken at the first edge after reset, before ready has been shown
  assign take = ready_reg && (state_reg == asrc_pkg::ASRC_IDLE) && req_valid_i;
  assign take_rd = take && !req_write_i;
  assign take_wr = take && req_write_i;

  // phase sequencing; timer sets each phase length
  always_comb
  begin
    state_next = state_reg;
    load = 1'b0;
    load_val = asrc_pkg::CNT_ZERO;
    case (state_reg)
      asrc_pkg::ASRC_IDLE:
      begin
        if (take_rd)
        begin
          state_next = asrc_pkg::ASRC_RD;
          load = 1'b1;
          // extra cycles cover the two-stage data synchroniser
          load_val = asrc_pkg::CNT_W'(asrc_pkg::RD_CYC + 1);
        end
        else if (take_wr)
        begin
          state_next = asrc_pkg::ASRC_WR;
          load = 1'b1;
          load_val = asrc_pkg::CNT_W'(asrc_pkg::WR_CYC);
        end
      end
      asrc_pkg::ASRC_RD:
        if (done)
        begin
          state_next = asrc_pkg::ASRC_TURN;
          load = 1'b1;
          load_val = asrc_pkg::CNT_W'(asrc_pkg::TURN_CYC);
        end
      asrc_pkg::ASRC_WR:
        if (done)
        begin
          state_next = asrc_pkg::ASRC_HOLD;
          load = 1'b1;
          load_val = asrc_pkg::CNT_W'(1);
        end
      asrc_pkg::ASRC_HOLD:
        if (done)
          state_next = asrc_pkg::ASRC_IDLE;
      asrc_pkg::ASRC_TURN:
        if (done)
          state_next = asrc_pkg::ASRC_IDLE;
      default:
        state_next = asrc_pkg::ASRC_IDLE;
    endcase
  end

  // pin levels follow the phase entered next, so each pin moves on the
  // same edge as the state and is glitch free at the memory
  assign nx_rd = (state_next == asrc_pkg::ASRC_RD);
  assign nx_wr = (state_next == asrc_pkg::ASRC_WR);
  assign nx_hold = (state_next == asrc_pkg::ASRC_HOLD);
  assign nx_idle = (state_next == asrc_pkg::ASRC_IDLE);
  // select low through the whole read or write phase
  assign cs_n_next = !(nx_rd || nx_wr);
  // strobe low only while writing, never in a read
  assign we_n_next = !nx_wr;
  // enable only in reads, so a write never meets a driving device
  assign oe_n_next = !nx_rd;
  // host drives from strobe fall through two hold cycles
  assign doe_next = nx_wr || nx_hold;
  assign ready_next = nx_idle;
  // last read cycle: the synchronised word is taken here
  assign rd_done = (state_reg == asrc_pkg::ASRC_RD) && done;

  // state and pin registers
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= asrc_pkg::ASRC_IDLE;
      cs_n_reg <= 1'b1;  // deselected, standby
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      doe_reg <= 1'b0;
      ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      cs_n_reg <= cs_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      doe_reg <= doe_next;
    end
  end

  // address and data hold for the whole cycle
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      addr_reg <= '0;
      wdata_reg <= '0;
    end
    else if (take)
    begin
      addr_reg <= req_addr_i;
      wdata_reg <= req_wdata_i;
    end
  end

  // pin input synchroniser, then capture at end of read
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= data_io_i;
      sync2_reg <= sync1_reg;
      rvalid_reg <= rd_done;
      if (rd_done)
        rdata_reg <= sync2_reg;
    end
  end

  // outputs straight from flip-flops
  assign word_index_o = addr_reg;
  assign chip_sel_n_o = cs_n_reg;
  assign wr_strobe_n_o = we_n_reg;
  assign out_en_n_o = oe_n_reg;
  assign data_io_o = wdata_reg;
  assign data_io_oe_o = doe_reg;
  assign req_ready_o = ready_reg;
  assign rsp_valid_o = rvalid_reg;
  assign rsp_rdata_o = rdata_reg;
endmodule
`default_nettype wire

/* tb/asrc_sram_model.sv */
// behavioural 16k x 4 asynchronous static memory
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model #(
  parameter int T_ACC = 12
) (
  // memory pins
  input wire logic [13:0] word_index_i,
  input wire logic chip_sel_n_i,
  input wire logic wr_strobe_n_i,
  input wire logic out_en_n_i,
  input wire logic [3:0] data_i,
  // device drive
  output logic drive_o,
  output logic [3:0] q_o
);
  logic [3:0] mem [16384];
  // drive only when selected, enabled and not writing
  wire rd_on = !chip_sel_n_i && !out_en_n_i && wr_strobe_n_i;
  // store at the end of the select and strobe overlap
  always @(posedge (chip_sel_n_i | wr_strobe_n_i))
  begin
    mem[word_index_i] <= data_i;
  end
  assign #4 drive_o = rd_on;
  assign #T_ACC q_o = mem[word_index_i];
endmodule
`default_nettype wire

/* tb/asrc_host_properties.sv */
// pin timing checks for the host
`timescale 1ns/1ps
`default_nettype none
module asrc_host_properties (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // memory pins and answer
  input wire logic [13:0] word_index_o,
  input wire logic chip_sel_n_o,
  input wire logic wr_strobe_n_o,
  input wire logic out_en_n_o,
  input wire logic [3:0] data_io_o,
  input wire logic data_io_oe_o,
  input wire logic rsp_valid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_write_overlap: assert property (!wr_strobe_n_o |-> !chip_sel_n_o && data_io_oe_o)
    else $error("strobe low alone");
  a_read_no_strobe: assert property (!out_en_n_o |-> wr_strobe_n_o && !data_io_oe_o)
    else $error("strobe in read");
  a_addr_held: assert property ($fell(chip_sel_n_o) |=> $stable(word_index_o))
    else $error("address moved");
  a_strobe_width: assert property ($fell(wr_strobe_n_o) |=> !wr_strobe_n_o ##1 wr_strobe_n_o)
    else $error("strobe width");
  a_data_setup: assert property ($rose(wr_strobe_n_o) |-> data_io_oe_o && $stable(data_io_o))
    else $error("data setup");
  a_select_width: assert property ($fell(chip_sel_n_o) |=> !chip_sel_n_o)
    else $error("select width");
  a_read_answer: assert property ($fell(out_en_n_o) |-> ##5 rsp_valid_o)
    else $error("read answer late");
endmodule
bind asrc_host asrc_host_properties chk_u (.clk_sys_i, .rstn_i, .word_index_o, .chip_sel_n_o,
  .wr_strobe_n_o, .out_en_n_o, .data_io_o, .data_io_oe_o, .rsp_valid_o);
`default_nettype wire

/* tb/asrc_host_tb_top.sv */
// self-checking bench for the asynchronous sram host
`timescale 1ns/1ps
`default_nettype none
module asrc_host_tb_top;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [13:0] req_addr_i = 14'h0000;
  logic [3:0] req_wdata_i = 4'h0;
  logic req_ready_o, rsp_valid_o, drive, cs_n, we_n, oe_n, hoe;
  logic [3:0] rsp_rdata_o, hdat, q, bus;
  logic [13:0] idx;
  logic [13:0] ra [12];
  logic [3:0] shadow [16384]; // expected contents
  logic [3:0] exp_q [$]; // expected reads, oldest first
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 92;
  always #5 clk_sys_i = ~clk_sys_i;
  // a released bus shows a changing pattern, never stale data
  assign bus = hoe ? hdat : (drive ? q : cyc[3:0]);
  asrc_host dut_u (.clk_sys_i, .rstn_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i,
    .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .word_index_o(idx), .chip_sel_n_o(cs_n),
    .wr_strobe_n_o(we_n), .out_en_n_o(oe_n), .data_io_i(bus), .data_io_o(hdat),
    .data_io_oe_o(hoe));
  asrc_sram_model mem_u (.word_index_i(idx), .chip_sel_n_i(cs_n), .wr_strobe_n_i(we_n),
    .out_en_n_i(oe_n), .data_i(bus), .drive_o(drive), .q_o(q));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one request, held until taken; reads note their expected word
  task automatic req(input logic w, input logic [13:0] a, input logic [3:0] d);
    @(negedge clk_sys_i);
    req_valid_i = 1'b1;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    while (req_ready_o !== 1'b1)
      @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    if (w)
      shadow[a] = d;
    else
      exp_q.push_back(shadow[a]);
  endtask
  task automatic cmp_data(input logic [3:0] e);
    check_count++;
    if (rsp_rdata_o !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: read %h not %h", $time, rsp_rdata_o, e);
    end
  endtask
  // read answers stand one cycle, so look mid-cycle
  always @(negedge clk_sys_i)
    if (rsp_valid_o === 1'b1)
    begin
      if (exp_q.size() > 0)
        cmp_data(exp_q.pop_front());
      else
      begin
        n_errors++;
        $display("unexpected at %0t: read answer not asked for", $time);
      end
    end
  // hang guard
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_errors++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (3) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    // corner words, then a rewrite of one word back to back
    req(1'b1, 14'h0000, 4'hA);
    req(1'b1, 14'h3FFF, 4'h5);
    req(1'b1, 14'h3FFF, 4'hC);
    req(1'b0, 14'h0000, 4'h0);
    req(1'b0, 14'h3FFF, 4'h0);
    req(1'b0, 14'h3FFF, 4'h0);
    $display("test corners done");
    // random words written, then read back in reverse
    for (int i = 0; i < 12; i++)
    begin
      ra[i] = 14'($random(seed));
      req(1'b1, ra[i], 4'($random(seed)));
    end
    for (int i = 11; i >= 0; i--)
      req(1'b0, ra[i], 4'h0);
    repeat (10) @(negedge clk_sys_i);
    $display("test random done");
    check_count++;
    if (exp_q.size() != 0)
    begin
      n_errors++;
      $display("unexpected at %0t: reads unanswered", $time);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
